/* File: rtl/scf_defs.svh */
// Purpose: constants of the serial port control and status flag block
// Assumes: 32-bit AXI4-Lite register bus, byte-wide registers in the low bits
// Notes:   included by its bare name, guarded against double inclusion
// Function
// - A data register write during a transfer sets the write collision flag and raises the interrupt.
// - A master mode collision sets the mode fault flag and raises the interrupt.
// - A master collision is select pin low with port enable and master enable set and select mode 01.
// - Select mode 00 is 3-wire operation and the select signal reaches no pin.
// - Select mode 01, the reset default, is 4-wire slave or multi-master with the select pin as input.
// - Select mode 1x drives the select pin as an output equal to the low mode bit.
// - Each byte end sets the transfer done flag, which hardware never clears and which raises the interrupt.
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH
`define SCF_OFF_CTRL      8'h00
`define SCF_OFF_DATA      8'h04
`define SCF_OFF_INT_STAT  8'h08
`define SCF_OFF_INT_CLR   8'h0C
`define SCF_OFF_INT_EN    8'h10
`define SCF_OFF_CFG       8'h14
`define SCF_B_DONE        7
`define SCF_B_COLL        6
`define SCF_B_FAULT       5
`define SCF_B_OVR         4
`define SCF_B_MODE_HI     3
`define SCF_B_MODE_LO     2
`define SCF_B_TXE         1
`define SCF_B_EN          0
`define SCF_B_MASTER      0
`define SCF_INT_MASK      8'hF0
`define SCF_MODE_3W       2'h0
`define SCF_MODE_4W       2'h1
`define SCF_MODE_RST      2'h1
`define SCF_LAST_BIT      3'h7
`define SCF_RESP_OKAY     2'h0
`define SCF_RESP_SLVERR   2'h2
`endif

/* File: rtl/scf_pkg.sv */
// Purpose: shared types of the serial port control and status flag block
// Assumes: constants live in scf_defs.svh
// Notes:   types only
package scf_pkg;
   typedef logic [1:0] scf_mode_t;
   typedef logic [7:0] scf_byte_t;
   typedef enum logic {WR_COLLECT, WR_RESPOND} scf_wr_e;
endpackage

/* File: rtl/scf_pin_if.sv */
// Purpose: carries raw pin levels to the synchroniser and synced levels back
// Assumes: bit 0 is the select pin, bit 1 the serial clock pin
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface scf_pin_if;
   logic [1:0] raw;
   logic [1:0] synced;
   modport user (output raw, input synced);
   modport sync (input raw, output synced);
endinterface
`default_nettype wire

/* File: rtl/scf_sync.sv */
// Purpose: two flip-flop synchroniser for the pin inputs
// Assumes: pins are asynchronous to CLOCK
// Notes:   the first stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none
module scf_sync (
   input wire logic clk,     // system clock
   input wire logic rst_n,   // async reset, active low
   scf_pin_if.sync  pins     // raw in, synced out
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;

   // reset to idle-high so a released port does not see a false select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 2'h3;
         sync_q <= 2'h3;
      end else begin
         meta_q <= pins.raw;
         sync_q <= meta_q;
      end
   end

   assign pins.synced = sync_q;
endmodule
`default_nettype wire

/* File: rtl/scf_top.sv */
// Purpose: control and status flags of the serial port with an AXI4-Lite slave
// Assumes: shift engine on CLOCK supplies busy, load and received byte
// Notes:   serial clock pin is sampled and its rising edges counted per byte
`timescale 1ns/1ps
`include "scf_defs.svh"
`default_nettype none
module scf_top
   import scf_pkg::*;
(
   input  wire logic        CLOCK,          // system clock, 100 MHz
   input  wire logic        RST_N,          // async reset, active low
   input  wire logic [7:0]  S_AXI_AWADDR,   // write address
   input  wire logic        S_AXI_AWVALID,  // write address valid
   output logic             S_AXI_AWREADY,  // write address ready
   input  wire logic [31:0] S_AXI_WDATA,    // write data
   input  wire logic [3:0]  S_AXI_WSTRB,    // write strobes
   input  wire logic        S_AXI_WVALID,   // write data valid
   output logic             S_AXI_WREADY,   // write data ready
   output logic [1:0]       S_AXI_BRESP,    // write response
   output logic             S_AXI_BVALID,   // write response valid
   input  wire logic        S_AXI_BREADY,   // write response ready
   input  wire logic [7:0]  S_AXI_ARADDR,   // read address
   input  wire logic        S_AXI_ARVALID,  // read address valid
   output logic             S_AXI_ARREADY,  // read address ready
   output logic [31:0]      S_AXI_RDATA,    // read data
   output logic [1:0]       S_AXI_RRESP,    // read response
   output logic             S_AXI_RVALID,   // read data valid
   input  wire logic        S_AXI_RREADY,   // read data ready
   input  wire logic        SEL_IN,         // select pin level
   output logic             SEL_OUT,        // select pin drive value
   output logic             SEL_OE,         // select pin drive enable
   input  wire logic        SCK_IN,         // serial clock pin level
   input  wire logic        XFER_BUSY,      // shift engine transfer in progress
   input  wire logic        SHIFT_LOAD,     // pulse: tx byte moved to shift reg
   input  wire logic [7:0]  RX_BYTE,        // byte shifted in by the engine
   output logic [7:0]       TX_BYTE,        // transmit buffer contents
   output logic             TX_FULL,        // transmit buffer holds a byte
   output logic             PORT_EN,        // port enable to the engine
   output logic             MASTER_EN,      // master enable to the engine
   output logic             IRQ             // level interrupt
);
   scf_pin_if pins ();
   logic      sel_pin_s;
   logic      sck_s;
   logic      sck_prev_q;
   logic [2:0] bit_cnt_q;
   logic      aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0] aw_addr_q;
   scf_byte_t wdata_q;
   logic      wstrb0_q;
   logic [1:0] bresp_q, rresp_q;
   scf_byte_t rdata_q;
   scf_wr_e   wr_st_q;
   logic      done_q, coll_q, fault_q, ovr_q, txe_q, en_q, master_q;
   scf_mode_t mode_q;
   scf_byte_t tx_buf_q, rx_buf_q;
   logic      rx_unread_q;
   scf_byte_t int_stat_q, int_en_q;
   scf_byte_t ctrl_rd, rd_mux, events;
   logic      wr_fire, rd_fire, wr_ctrl, wr_data, rd_data, busy;
   logic      sel_off, sck_rise, byte_end, fault, coll_ev, ovr_ev, rd_hit;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   // pins cross into CLOCK before anything looks at them
   assign pins.raw = {SCK_IN, SEL_IN};
   scf_sync u_sync (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .pins  (pins)
   );
   assign sel_pin_s = pins.synced[0];
   assign sck_s = pins.synced[1];

   // ---- AXI4-Lite write channel: address and data taken in either order
   assign S_AXI_AWREADY = !aw_have_q && (wr_st_q == WR_COLLECT);
   assign S_AXI_WREADY  = !w_have_q && (wr_st_q == WR_COLLECT);
   assign wr_fire       = aw_have_q && w_have_q && (wr_st_q == WR_COLLECT);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         w_have_q <= 1'b0;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_q <= 1'b1;
         wdata_q  <= S_AXI_WDATA[7:0];
         wstrb0_q <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   // response state; unmapped addresses answer SLVERR and change nothing
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_st_q  <= WR_COLLECT;
         bvalid_q <= 1'b0;
         bresp_q  <= `SCF_RESP_OKAY;
      end else begin
         case (wr_st_q)
            WR_COLLECT: begin
               if (wr_fire) begin
                  wr_st_q  <= WR_RESPOND;
                  bvalid_q <= 1'b1;
                  bresp_q  <= (aw_addr_q <= `SCF_OFF_CFG && aw_addr_q[1:0] == 2'h0 &&
                               aw_addr_q != `SCF_OFF_INT_STAT) ? `SCF_RESP_OKAY : `SCF_RESP_SLVERR;
               end
            end
            WR_RESPOND: begin
               if (S_AXI_BREADY) begin
                  wr_st_q  <= WR_COLLECT;
                  bvalid_q <= 1'b0;
               end
            end
            default: wr_st_q <= WR_COLLECT;
         endcase
      end
   end
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP  = bresp_q;

   a_write_resp_time: assert property (wr_fire |=> S_AXI_BVALID && $stable(aw_addr_q))
      else $error("write response not raised one cycle after the write");

   assign wr_ctrl = wr_fire && wstrb0_q && (aw_addr_q == `SCF_OFF_CTRL);
   assign wr_data = wr_fire && wstrb0_q && (aw_addr_q == `SCF_OFF_DATA);

   // ---- AXI4-Lite read channel, one read outstanding
   assign S_AXI_ARREADY = !rvalid_q;
   assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;
   assign rd_data       = rd_fire && (S_AXI_ARADDR == `SCF_OFF_DATA);
   assign ctrl_rd = {done_q, coll_q, fault_q, ovr_q, mode_q, txe_q, en_q};

   always_comb begin
      rd_mux = 8'h00;
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         `SCF_OFF_CTRL:     rd_mux = ctrl_rd;
         `SCF_OFF_DATA:     rd_mux = rx_buf_q;
         `SCF_OFF_INT_STAT: rd_mux = int_stat_q;
         `SCF_OFF_INT_CLR:  rd_mux = 8'h00;
         `SCF_OFF_INT_EN:   rd_mux = int_en_q;
         `SCF_OFF_CFG:      rd_mux = {7'h00, master_q};
         default:           rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 8'h00;
         rresp_q  <= `SCF_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_hit ? `SCF_RESP_OKAY : `SCF_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA  = {24'h000000, rdata_q};
   assign S_AXI_RRESP  = rresp_q;

   // ---- link side: count sampled serial clock rising edges per byte
   // a deselected 4-wire slave restarts the count so a stray edge cannot shift the frame
   assign sel_off  = !master_q && (mode_q == `SCF_MODE_4W) && sel_pin_s;
   assign sck_rise = sck_s && !sck_prev_q;
   assign byte_end = en_q && !sel_off && sck_rise && (bit_cnt_q == `SCF_LAST_BIT);
   assign busy     = XFER_BUSY || (bit_cnt_q != 3'h0);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sck_prev_q <= 1'b1;
         bit_cnt_q  <= 3'h0;
      end else begin
         sck_prev_q <= sck_s;
         if (!en_q || sel_off) begin
            bit_cnt_q <= 3'h0;
         end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;  // wraps to zero after the last bit
         end
      end
   end

   // fault only in multi-master mode; 3-wire mode ignores the select pin
   assign fault   = en_q && master_q && !sel_pin_s && (mode_q == `SCF_MODE_4W);
   assign coll_ev = wr_data && busy;
   assign ovr_ev  = byte_end && !master_q && rx_unread_q;

   // select pin drive: only the single-master modes own the pin
   assign SEL_OE  = mode_q[1];
   assign SEL_OUT = mode_q[1] & mode_q[0];

   a_sel_drive_mode: assert property (mode_q[1] |-> SEL_OE && (SEL_OUT == mode_q[0]))
      else $error("select pin not driven with the low mode bit");
   a_sel_input_modes: assert property (!mode_q[1] |-> !SEL_OE && !SEL_OUT)
      else $error("select pin driven in a 3-wire or 4-wire input mode");

   // ---- control register; a hardware set wins over a software write of zero
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         done_q  <= 1'b0;
         coll_q  <= 1'b0;
         fault_q <= 1'b0;
         ovr_q  <= 1'b0;
      end else begin
         done_q <= (wr_ctrl ? wdata_q[`SCF_B_DONE] : done_q) | byte_end;
         coll_q  <= (wr_ctrl ? wdata_q[`SCF_B_COLL] : coll_q) | coll_ev;
         fault_q <= (wr_ctrl ? wdata_q[`SCF_B_FAULT] : fault_q) | fault;
         ovr_q  <= (wr_ctrl ? wdata_q[`SCF_B_OVR]  : ovr_q)  | ovr_ev;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q   <= `SCF_MODE_RST;
         en_q     <= 1'b0;
         master_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            mode_q <= wdata_q[`SCF_B_MODE_HI:`SCF_B_MODE_LO];
            en_q   <= wdata_q[`SCF_B_EN];
         end
         if (wr_fire && wstrb0_q && aw_addr_q == `SCF_OFF_CFG) begin
            master_q <= wdata_q[`SCF_B_MASTER];
         end
      end
   end
   assign PORT_EN   = en_q;
   assign MASTER_EN = master_q;

   a_coll_on_busy: assert property (wr_data && busy |=> coll_q && $stable(tx_buf_q))
      else $error("busy data write did not set write collision");
   a_fault_flag_set: assert property (fault |=> fault_q ##1 (fault_q || $past(wr_ctrl)))
      else $error("mode fault flag not set on master collision");
   a_fault_held: assert property (fault_q && !wr_ctrl |=> fault_q)
      else $error("mode fault flag cleared without software");
   a_done_on_byte: assert property (byte_end |=> done_q && int_stat_q[`SCF_B_DONE])
      else $error("byte end did not set transfer done");
   a_done_held: assert property (done_q && !wr_ctrl |=> done_q)
      else $error("transfer done cleared by hardware");
   // software may set the flag by writing one, so only hardware rises are checked
   a_ovr_slave_only: assert property ($rose(ovr_q) && !$past(wr_ctrl) |-> !$past(master_q) && $past(rx_unread_q))
      else $error("overrun flagged in master mode or without unread data");

   // ---- transmit buffer; a refused write leaves the buffer untouched
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         tx_buf_q <= 8'h00;
         txe_q    <= 1'b1;
      end else if (wr_data && !busy) begin
         tx_buf_q <= wdata_q;
         txe_q    <= 1'b0;
      end else if (SHIFT_LOAD) begin
         txe_q    <= 1'b1;
      end
   end
   assign TX_BYTE = tx_buf_q;
   assign TX_FULL = !txe_q;

   a_txe_low_write: assert property (wr_data && !busy |=> !txe_q && (tx_buf_q == $past(wdata_q)))
      else $error("transmit buffer empty stayed high after a write");
   a_txe_high_load: assert property (SHIFT_LOAD && !wr_data |=> txe_q)
      else $error("transmit buffer empty not restored after load");

   // ---- receive buffer; on overrun the unread byte is kept, the new one lost
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rx_buf_q    <= 8'h00;
         rx_unread_q <= 1'b0;
      end else if (byte_end && !ovr_ev) begin
         rx_buf_q    <= RX_BYTE;
         rx_unread_q <= 1'b1;
      end else if (rd_data) begin
         rx_unread_q <= 1'b0;
      end
   end

   // ---- interrupt status: sticky, write-one-to-clear, set beats clear
   assign events = {byte_end, coll_ev, fault, ovr_ev, 4'h0};

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         int_stat_q <= 8'h00;
         int_en_q   <= 8'h00;
      end else begin
         if (wr_fire && wstrb0_q && aw_addr_q == `SCF_OFF_INT_CLR) begin
            int_stat_q <= ((int_stat_q & ~wdata_q) | events) & `SCF_INT_MASK;
         end else begin
            int_stat_q <= (int_stat_q | events) & `SCF_INT_MASK;
         end
         if (wr_fire && wstrb0_q && aw_addr_q == `SCF_OFF_INT_EN) begin
            int_en_q <= wdata_q & `SCF_INT_MASK;
         end
      end
   end
   assign IRQ = |(int_stat_q & int_en_q);

   a_irq_on_coll: assert property (coll_ev && int_en_q[`SCF_B_COLL] |=> IRQ)
      else $error("enabled write collision did not raise the interrupt");
endmodule
`default_nettype wire

/* File: test/scf_far_model.sv */
// Purpose: far-side serial master that sends whole bytes on request
// Assumes: serial clock idles low and stands still between frames
// Notes:   select is pulled up, so it reads high whenever it is released
`timescale 1ns/1ps
`default_nettype none
module scf_far_model (
   input  wire logic go,    // rising edge starts one frame
   input  wire logic sel,   // pull select low during the frame
   output logic      sck,   // serial clock, 125 ns period in frames
   output logic      ss_lvl, // select level
   output logic      busy   // frame under way
);
   // idle levels: clock low, select released
   initial begin
      sck = 1'b0;
      ss_lvl = 1'b1;
      busy = 1'b0;
   end

   // one byte: select setup, eight clock periods, select hold
   always @(posedge go) begin
      busy = 1'b1;
      ss_lvl = !sel;
      #250;
      repeat (8) begin
         sck = 1'b1;
         #62.5;
         sck = 1'b0;
         #62.5;
      end
      #250;
      ss_lvl = 1'b1;
      #100;
      busy = 1'b0;
   end
endmodule
`default_nettype wire

/* File: test/scf_top_tb.sv */
// Purpose: self-checking bench for the serial port control and status flags
// Assumes: AXI4-Lite master tasks, far model makes its own serial clock
// Notes:   expected reads and write responses are queued and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module scf_top_tb;
   import scf_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr, rx_byte, v1, v2, v3;
   logic [31:0] wdata, rdata, st;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, sel_out, sel_oe, tx_full;
   logic        port_en, master_en, irq, xfer_busy, shift_load, go, sel, sel_hold;
   logic        sck, far_sel, far_busy, sel_pin;
   logic [7:0]  tx_byte;
   logic [3:0]  wstrb;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          mismatches, n_compared;

   // pin level: the port drives when enabled, else far side and bench pull-down share it
   assign sel_pin = sel_oe ? sel_out : (far_sel & sel_hold);

   scf_top i_dut (.CLOCK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SEL_IN(sel_pin),
      .SEL_OUT(sel_out), .SEL_OE(sel_oe), .SCK_IN(sck), .XFER_BUSY(xfer_busy), .SHIFT_LOAD(shift_load),
      .RX_BYTE(rx_byte), .TX_BYTE(tx_byte), .TX_FULL(tx_full), .PORT_EN(port_en),
      .MASTER_EN(master_en), .IRQ(irq));

   scf_far_model i_far (.go(go), .sel(sel), .sck(sck), .ss_lvl(far_sel), .busy(far_busy));

   always #5 clk = !clk;

   task automatic summarize();
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // xorshift, so every run sees the same bytes
   function automatic logic [7:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st[7:0];
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // readies are looked at on the falling edge, where they are settled, then released after the rise
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
      int n;
      logic pa, pw, pb, ta, tw, tb;
      @(posedge clk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      for (n = 0; n < 200 && (pa || pw || pb); n++) begin
         @(negedge clk);
         ta = pa && awready;
         tw = pw && wready;
         tb = !pa && !pw && bvalid;
         @(posedge clk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         if (tb) begin
            bready <= 1'b0;
            pb = 1'b0;
         end
      end
      if (n >= 200) mismatches++;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
      int n;
      logic pa, pr, ta, tr;
      @(posedge clk);
      rq.push_back({r, 24'h0, e});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      pr = 1'b1;
      for (n = 0; n < 200 && pr; n++) begin
         @(negedge clk);
         ta = pa && arready;
         tr = !pa && rvalid;
         @(posedge clk);
         if (ta) begin
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tr) begin
            rready <= 1'b0;
            pr = 1'b0;
         end
      end
      if (n >= 200) mismatches++;
   endtask

   task automatic frame(input logic s);
      int n;
      @(posedge clk);
      sel <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 400 && far_busy; n++) @(posedge clk);
      cyc(4);
   endtask

   // monitor: each answer takes the oldest note off its queue
   always @(negedge clk) begin
      if (rvalid && rready)
         chk("read", {rresp, 24'h0, rdata[7:0]} | 34'(rdata[31:8] << 8), rq.size() ? rq.pop_front() : '1);
      if (bvalid && bready)
         chk("bresp", 34'(bresp), 34'(bq.size() ? bq.pop_front() : 2'h3));
   end

   initial begin
      #300000;
      mismatches++;
      summarize();
   end

   initial begin
      {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, xfer_busy, shift_load, go, sel} = '0;
      {awaddr, araddr, wdata, rx_byte} = '0;
      sel_hold = 1'b1;
      wstrb = 4'hF;
      st = 32'd86;
      mismatches = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 8'h06);
      chk("oe", 34'(sel_oe), 34'h0);
      rd(8'h18, 8'h00, 2'h2);
      wr(8'h08, 8'hFF, 2'h2);
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 8'(m * 4 + 1));
         chk("oe", 34'(sel_oe), 34'(m[1]));
         chk("out", 34'(sel_out & sel_oe), 34'(m[1] & m[0]));
         rd(8'h00, 8'(m * 4 + 3));
      end
      // a write with its low byte lane off leaves the register alone
      wstrb <= 4'hE;
      wr(8'h00, 8'h00);
      wstrb <= 4'hF;
      rd(8'h00, 8'h0F);
      // 3-wire: select left high still counts the byte
      wr(8'h00, 8'h01);
      v1 = rnd();
      rx_byte <= v1;
      frame(1'b0);
      rd(8'h00, 8'h83);
      rd(8'h04, v1);
      wr(8'h0C, 8'hF0);
      wr(8'h00, 8'h05);
      frame(1'b0);
      rd(8'h00, 8'h07);
      v2 = rnd();
      rx_byte <= v2;
      frame(1'b1);
      wr(8'h10, 8'h80);
      chk("irq", 34'(irq), 34'h1);
      v3 = rnd();
      rx_byte <= v3;
      frame(1'b1);
      rd(8'h00, 8'h97);
      rd(8'h08, 8'h90);
      rd(8'h04, v2);
      wr(8'h10, 8'h00);
      chk("irq", 34'(irq), 34'h0);
      wr(8'h0C, 8'hF0);
      wr(8'h00, 8'h05);
      // transmit buffer empties only when the byte is loaded
      v1 = rnd();
      wr(8'h04, v1);
      chk("txfull", 34'(tx_full), 34'h1);
      chk("txbyte", 34'(tx_byte), 34'(v1));
      rd(8'h00, 8'h05);
      shift_load <= 1'b1;
      @(posedge clk);
      shift_load <= 1'b0;
      rd(8'h00, 8'h07);
      // data write during a transfer, collision interrupt enabled first
      wr(8'h10, 8'h40);
      xfer_busy <= 1'b1;
      wr(8'h04, rnd());
      xfer_busy <= 1'b0;
      chk("txfull", 34'(tx_full), 34'h0);
      chk("irq", 34'(irq), 34'h1);
      rd(8'h00, 8'h47);
      wr(8'h00, 8'h05);
      rd(8'h00, 8'h07);
      wr(8'h0C, 8'h40);
      chk("irq", 34'(irq), 34'h0);
      // master with select pulled low in 4-wire mode
      wr(8'h14, 8'h01);
      chk("master", 34'({master_en, port_en}), 34'h3);
      sel_hold <= 1'b0;
      cyc(6);
      rd(8'h00, 8'h27);
      wr(8'h10, 8'h20);
      chk("irq", 34'(irq), 34'h1);
      sel_hold <= 1'b1;
      cyc(6);
      rd(8'h00, 8'h27);
      wr(8'h00, 8'h05);
      rd(8'h00, 8'h07);
      wr(8'h0C, 8'h20);
      chk("irq", 34'(irq), 34'h0);
      wr(8'h00, 8'h01);
      sel_hold <= 1'b0;
      cyc(6);
      rd(8'h00, 8'h03);
      sel_hold <= 1'b1;
      cyc(4);
      summarize();
   end
endmodule
`default_nettype wire
